// *** include/rcl_pkg.sv ***
// rcl_pkg: constants, states and carriers of the rom config loader
// assumes a single 50 MHz clock; all pins sampled synchronously
package rcl_pkg;

  // ---------------------------------------------------------------
  // widths and addresses
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int CFG_IDX_W = 12;
  localparam logic [19:0] PAR_LOAD_BASE = 20'h01000;
  localparam logic [7:0] SER_LOAD_BASE = 8'h00;
  localparam logic [6:0] SER_DEV_ADDR = 7'h50;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 60;
  localparam int ACCESS_NS = 150;
  localparam int I2C_HALF_NS = 5000;
  localparam logic [7:0] STROBE_CYC =
    8'((STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACCESS_CYC =
    8'((ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] I2C_HALF_CYC =
    8'((I2C_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ---------------------------------------------------------------
  // states and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_LAT0 = 3'b001, M_LAT1 = 3'b010,
    M_ACC = 3'b011, M_DONE = 3'b100
  } rcl_mem_e;

  typedef enum logic [2:0] {
    I_IDLE = 3'b000, I_START = 3'b001, I_BIT = 3'b010, I_STOP = 3'b011
  } rcl_i2c_e;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00, SRC_PAR = 2'b01, SRC_SER = 2'b10
  } rcl_src_e;

  typedef struct packed {
    logic [2:0] priAddr;
    logic [2:0] secAddr;
    logic [1:0] priSel;
    logic [1:0] secSel;
    logic priCable;
    logic secCable;
    logic [15:0] secData;
    logic [1:0] secDataOe;
  } rcl_pins_s;

  typedef struct packed {
    logic write;
    logic [19:0] addr;
    logic [7:0] wdata;
  } rcl_req_s;

  typedef struct packed {
    logic [11:0] idx;
    logic [7:0] data;
  } rcl_cfg_s;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam rcl_pins_s PINS_RST = '0;
  localparam logic HOST_PREV_RST = 1'b0;

endpackage : rcl_pkg

// *** hdl/rcl_strap_capture.sv ***
// rcl_strap_capture: latches the three straps as bus reset rises
// assumes the strap pins are released by this device during bus reset
`timescale 1ns/10ps
module rcl_strap_capture
  import rcl_pkg::*;
(
  input logic ref_clk,
  input logic rstn,
  input logic clkEn,
  input logic hostBusResetN,
  input logic oeStrap,
  input logic weStrap,
  input logic floatStrap,
  output logic strapValid,
  output logic allocEnable,
  output rcl_src_e loadSrc
);

  logic hostPrev_q, hostPrev_d, valid_q, valid_d, alloc_q, alloc_d;
  rcl_src_e src_q, src_d;

  always_comb begin
    hostPrev_d = hostBusResetN;
    valid_d = hostBusResetN && !hostPrev_q;
    alloc_d = alloc_q;
    src_d = src_q;
    if (valid_d) begin
      // R5 alloc mode strap
      alloc_d = !oeStrap;
      // R7 R14 source selection
      if (!floatStrap) begin
        src_d = SRC_SER;
      end else if (weStrap) begin
        src_d = SRC_PAR;
      end else begin
        src_d = SRC_NONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      hostPrev_q <= HOST_PREV_RST;
      valid_q <= 1'b0;
      alloc_q <= 1'b0;
      src_q <= SRC_NONE;
    end else if (clkEn) begin
      hostPrev_q <= hostPrev_d;
      valid_q <= valid_d;
      alloc_q <= alloc_d;
      src_q <= src_d;
    end
  end

  assign strapValid = valid_q;
  assign allocEnable = alloc_q;
  assign loadSrc = src_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !clkEn);

  a_alloc_strap : assert property ( // R5
    (hostBusResetN && !hostPrev_q) |=>
      (allocEnable == !$past(oeStrap)) && strapValid)
    else $error("alloc mode not taken from oe strap");

  a_src_strap : assert property ( // R7
    (hostBusResetN && !hostPrev_q && floatStrap && weStrap) |=>
      loadSrc == SRC_PAR)
    else $error("parallel load source not selected");

endmodule : rcl_strap_capture

// *** hdl/rcl_loader.sv ***
// rcl_loader: shared-pin rom access and configuration load engine
// assumes pins are synchronous to ref_clk and the ide core supplies
// its own pin values on ideIn whenever it owns the shared pins
//
// How it works
// R1 - address up to 20 bits built from bus, strobes and latches
// R2 - address goes out low byte first, top bits last
// R3 - same bus carries flash write data and captures read data
// R4 - output enable driven low during memory reads
// R5 - oe pin level at bus reset rise picks allocation mode
// R6 - write enable driven low to write flash
// R7 - we and float straps both high load from parallel rom
// R8 - oe pin doubles as serial clock, we pin as serial data
// R9 - primary ide address pins also carry chip select and address
// R10 - low byte of secondary ide data is the memory data bus
// R11 - 17 address lines ride on cable ids, selects and ide pins
// R12 - secondary ide address outputs carry address bits 10 to 8
// R13 - secondary ide data pins carry memory data and address
// R14 - float strap low at reset rise loads from serial rom
// R15 - serial load starts at 0, parallel load at 1000H
// R16 - ide pins held off ide use during memory work, then returned
`timescale 1ns/10ps
module rcl_loader
  import rcl_pkg::*;
#(
  parameter int LOAD_BYTES = 64
) (
  input logic ref_clk,
  input logic rstn,
  input logic clkEn,
  input logic hostBusResetN,
  input logic ataFloatStrap,
  input rcl_pins_s ideIn,
  input logic [15:0] secDataIn,
  output rcl_pins_s pinOut,
  input logic romOutputEnableNIn,
  output logic romOutputEnableNOut,
  output logic romOutputEnableNOe,
  input logic romWriteEnableNIn,
  output logic romWriteEnableNOut,
  output logic romWriteEnableNOe,
  output logic [1:0] romAddrLatch,
  input logic reqValid,
  input rcl_req_s req,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic cfgValid,
  output rcl_cfg_s cfg,
  output logic loadBusy,
  output logic allocEnable,
  output rcl_src_e loadSrc,
  output logic idePinsOwned
);

  localparam logic [CFG_IDX_W-1:0] LAST_IDX = CFG_IDX_W'(LOAD_BYTES - 1);

  // R11 R12 R13 address bits onto shared pins
  function automatic rcl_pins_s mapAddr(rcl_pins_s p, logic [16:0] ma);
    rcl_pins_s r;
    r = p;
    r.priCable = ma[16];
    r.secCable = ma[15];
    r.priAddr[1:0] = ma[14:13];
    r.secSel = ma[12:11];
    r.secAddr = ma[10:8];
    r.secData[15:10] = ma[7:2];
    r.priSel = ma[1:0];
    return r;
  endfunction : mapAddr

  rcl_mem_e memSt_q, memSt_d;
  logic [7:0] memCnt_q, memCnt_d;
  rcl_req_s memReq_q, memReq_d;
  logic memDone, memGo, userTake, strapValid, byteDone;
  logic loadBusy_q, loadBusy_d, reqReady_q, reqReady_d;
  logic [CFG_IDX_W-1:0] loadCnt_q, loadCnt_d;
  logic cfgValid_q, cfgValid_d, rspValid_q, rspValid_d;
  rcl_cfg_s cfg_q, cfg_d;
  logic [7:0] rspData_q, rspData_d;
  rcl_i2c_e i2cSt_q, i2cSt_d;
  logic [7:0] i2cTmr_q, i2cTmr_d, i2cSh_q, i2cSh_d, serByte;
  logic [1:0] i2cPh_q, i2cPh_d, i2cByte_q, i2cByte_d;
  logic [3:0] i2cBit_q, i2cBit_d;
  logic serDone, serFail, sclHi, sdaLow, tick, reading, sdaIn, owned;
  rcl_pins_s pins_q, pins_d;
  logic [16:0] ma;
  logic oeOut_q, oeOut_d, oeOe_q, oeOe_d, weOut_q, weOut_d;
  logic weOe_q, weOe_d, owned_q;
  logic [1:0] latch_q, latch_d;

  rcl_strap_capture uStrap (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .hostBusResetN(hostBusResetN),
    .oeStrap(romOutputEnableNIn),
    .weStrap(romWriteEnableNIn),
    .floatStrap(ataFloatStrap),
    .strapValid(strapValid),
    .allocEnable(allocEnable),
    .loadSrc(loadSrc)
  );

  // ---------------------------------------------------------------
  // parallel memory cycle
  // ---------------------------------------------------------------
  assign userTake = reqValid && reqReady_q;
  assign memGo = (loadBusy_q && loadSrc == SRC_PAR) || userTake;

  always_comb begin
    memSt_d = memSt_q;
    memCnt_d = memCnt_q - 8'h01;
    memReq_d = memReq_q;
    memDone = 1'b0;
    unique case (memSt_q)
      M_IDLE: begin
        memCnt_d = STROBE_CYC;
        if (memGo) begin
          memSt_d = M_LAT0;
          // R15 parallel load from base
          memReq_d = loadBusy_q ? rcl_req_s'{write: 1'b0,
            addr: PAR_LOAD_BASE + ADDR_W'(loadCnt_q), wdata: 8'h00} : req;
        end
      end
      M_LAT0: if (memCnt_q == 8'h01) begin
        memSt_d = M_LAT1;
        memCnt_d = STROBE_CYC;
      end
      M_LAT1: if (memCnt_q == 8'h01) begin
        memSt_d = M_ACC;
        memCnt_d = ACCESS_CYC;
      end
      M_ACC: if (memCnt_q == 8'h01) begin
        memSt_d = M_DONE;
      end
      M_DONE: begin
        memDone = 1'b1;
        memSt_d = M_IDLE;
      end
      default: memSt_d = M_IDLE;
    endcase
    // bus reset aborts; strap pins must be left free
    if (!hostBusResetN) begin
      memSt_d = M_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      memSt_q <= M_IDLE;
      memCnt_q <= 8'h00;
      memReq_q <= '0;
    end else if (clkEn) begin
      memSt_q <= memSt_d;
      memCnt_q <= memCnt_d;
      memReq_q <= memReq_d;
    end
  end

  // ---------------------------------------------------------------
  // load sequencing and answers
  // ---------------------------------------------------------------
  assign byteDone = (memDone && loadBusy_q) || serDone;

  always_comb begin
    loadBusy_d = loadBusy_q;
    loadCnt_d = loadCnt_q;
    cfgValid_d = 1'b0;
    cfg_d = cfg_q;
    rspValid_d = 1'b0;
    rspData_d = rspData_q;
    if (strapValid) begin
      // R7 R14 start the selected load
      loadBusy_d = loadSrc != SRC_NONE;
      loadCnt_d = '0;
    end else if (byteDone) begin
      cfgValid_d = 1'b1;
      // R3 R10 read data from low data lanes
      cfg_d.data = memDone ? secDataIn[7:0] : serByte;
      cfg_d.idx = loadCnt_q;
      loadCnt_d = loadCnt_q + 1'b1;
      if (loadCnt_q == LAST_IDX) begin
        loadBusy_d = 1'b0;
      end
    end
    if (serFail || !hostBusResetN) begin
      loadBusy_d = 1'b0;
    end
    if (memDone && !loadBusy_q) begin
      rspValid_d = 1'b1;
      rspData_d = secDataIn[7:0];
    end
    reqReady_d = hostBusResetN && !loadBusy_d && memSt_d == M_IDLE &&
      i2cSt_d == I_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      loadBusy_q <= 1'b0;
      loadCnt_q <= '0;
      cfgValid_q <= 1'b0;
      cfg_q <= '0;
      rspValid_q <= 1'b0;
      rspData_q <= 8'h00;
      reqReady_q <= 1'b0;
    end else if (clkEn) begin
      loadBusy_q <= loadBusy_d;
      loadCnt_q <= loadCnt_d;
      cfgValid_q <= cfgValid_d;
      cfg_q <= cfg_d;
      rspValid_q <= rspValid_d;
      rspData_q <= rspData_d;
      reqReady_q <= reqReady_d;
    end
  end

  // ---------------------------------------------------------------
  // two-wire serial reader
  // ---------------------------------------------------------------
  // dummy write sets the word address, then a sequential read
  always_comb begin
    i2cSt_d = i2cSt_q;
    i2cPh_d = i2cPh_q;
    i2cBit_d = i2cBit_q;
    i2cByte_d = i2cByte_q;
    i2cSh_d = i2cSh_q;
    tick = i2cTmr_q == 8'h00;
    i2cTmr_d = tick ? I2C_HALF_CYC - 8'h01 : i2cTmr_q - 8'h01;
    reading = i2cByte_q == 2'd3;
    sdaIn = romWriteEnableNIn;
    serByte = {i2cSh_q[6:0], sdaIn};
    serDone = 1'b0;
    serFail = 1'b0;
    sclHi = 1'b1;
    sdaLow = 1'b0;
    unique case (i2cSt_q)
      I_IDLE: begin
        i2cTmr_d = I2C_HALF_CYC - 8'h01;
        if (loadBusy_q && loadSrc == SRC_SER) begin
          i2cSt_d = I_START;
          i2cPh_d = 2'd0;
          i2cByte_d = 2'd0;
        end
      end
      I_START: begin
        sclHi = i2cPh_q != 2'd0;
        sdaLow = i2cPh_q == 2'd2;
        if (tick) begin
          i2cPh_d = i2cPh_q + 2'd1;
          if (i2cPh_q == 2'd2) begin
            i2cSt_d = I_BIT;
            i2cPh_d = 2'd0;
            i2cBit_d = 4'd0;
            i2cSh_d = {SER_DEV_ADDR, i2cByte_q[1]};
          end
        end
      end
      I_BIT: begin
        sclHi = i2cPh_q[0];
        sdaLow = (i2cBit_q < 4'd8) ? (!reading && !i2cSh_q[7]) :
          (reading && loadBusy_q);
        if (tick && !i2cPh_q[0]) begin
          i2cPh_d = 2'd1;
        end else if (tick) begin
          i2cPh_d = 2'd0;
          i2cBit_d = i2cBit_q + 4'd1;
          if (i2cBit_q < 4'd8) begin
            i2cSh_d = serByte;
            serDone = reading && i2cBit_q == 4'd7;
          end else if (!reading && sdaIn) begin
            serFail = 1'b1;
            i2cSt_d = I_STOP;
          end else begin
            i2cBit_d = 4'd0;
            unique case (i2cByte_q)
              2'd0: begin
                i2cByte_d = 2'd1;
                // R15 serial load from word zero
                i2cSh_d = SER_LOAD_BASE;
              end
              2'd1: begin
                i2cByte_d = 2'd2;
                i2cSt_d = I_START;
              end
              2'd2: i2cByte_d = 2'd3;
              2'd3: if (!loadBusy_q) i2cSt_d = I_STOP;
            endcase
          end
        end
      end
      I_STOP: begin
        sclHi = i2cPh_q != 2'd0;
        sdaLow = i2cPh_q != 2'd2;
        if (tick && i2cPh_q == 2'd2) begin
          i2cSt_d = I_IDLE;
        end else if (tick) begin
          i2cPh_d = i2cPh_q + 2'd1;
        end
      end
      default: i2cSt_d = I_IDLE;
    endcase
    if (!hostBusResetN) begin
      i2cSt_d = I_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      i2cSt_q <= I_IDLE;
      i2cTmr_q <= 8'h00;
      i2cPh_q <= 2'd0;
      i2cBit_q <= 4'd0;
      i2cByte_q <= 2'd0;
      i2cSh_q <= 8'h00;
    end else if (clkEn) begin
      i2cSt_q <= i2cSt_d;
      i2cTmr_q <= i2cTmr_d;
      i2cPh_q <= i2cPh_d;
      i2cBit_q <= i2cBit_d;
      i2cByte_q <= i2cByte_d;
      i2cSh_q <= i2cSh_d;
    end
  end

  // ---------------------------------------------------------------
  // shared pin mux
  // ---------------------------------------------------------------
  // R16 memory work owns the ide pins
  assign owned = loadBusy_q || memSt_q != M_IDLE || i2cSt_q != I_IDLE;

  always_comb begin
    pins_d = ideIn;
    unique case (memSt_q)
      // R1 R2 low byte, then next byte, then top bits
      M_LAT0: ma = {9'h000, memReq_q.addr[7:0]};
      M_LAT1: ma = {9'h000, memReq_q.addr[15:8]};
      M_ACC, M_DONE: ma = {13'h0000, memReq_q.addr[19:16]};
      default: ma = 17'h00000;
    endcase
    if (owned) begin
      pins_d = mapAddr(ideIn, ma);
      // R9 chip select on primary address pin
      pins_d.priAddr[2] = memSt_q != M_ACC;
      // R3 R10 write data, low lane released for reads
      pins_d.secData[9:0] = {2'b00, memReq_q.wdata};
      pins_d.secDataOe = {1'b1, memReq_q.write &&
        (memSt_q == M_ACC || memSt_q == M_DONE)};
    end
    // R4 R6 active-low strobes
    oeOut_d = !(memSt_q == M_ACC && !memReq_q.write);
    weOut_d = !(memSt_q == M_ACC && memReq_q.write);
    oeOe_d = hostBusResetN;
    weOe_d = hostBusResetN;
    // R8 serial clock and open-drain data
    if (i2cSt_q != I_IDLE) begin
      oeOut_d = sclHi;
      weOut_d = 1'b0;
      weOe_d = sdaLow && hostBusResetN;
    end
    latch_d = {memSt_q == M_LAT1, memSt_q == M_LAT0};
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pins_q <= PINS_RST;
      oeOut_q <= 1'b1;
      oeOe_q <= 1'b0;
      weOut_q <= 1'b1;
      weOe_q <= 1'b0;
      latch_q <= 2'b00;
      owned_q <= 1'b0;
    end else if (clkEn) begin
      pins_q <= pins_d;
      oeOut_q <= oeOut_d;
      oeOe_q <= oeOe_d;
      weOut_q <= weOut_d;
      weOe_q <= weOe_d;
      latch_q <= latch_d;
      owned_q <= owned;
    end
  end

  assign pinOut = pins_q;
  assign romOutputEnableNOut = oeOut_q;
  assign romOutputEnableNOe = oeOe_q;
  assign romWriteEnableNOut = weOut_q;
  assign romWriteEnableNOe = weOe_q;
  assign romAddrLatch = latch_q;
  assign reqReady = reqReady_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign cfgValid = cfgValid_q;
  assign cfg = cfg_q;
  assign loadBusy = loadBusy_q;
  assign idePinsOwned = owned_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || !clkEn);

  a_lsb_first : assert property ( // R2
    $rose(romAddrLatch[1]) |-> $past(romAddrLatch[0]) &&
      mapAddr(pinOut, {9'h000, memReq_q.addr[15:8]}) == pinOut)
    else $error("address bytes out of order");

  a_hi_addr : assert property ( // R11
    (memSt_q == M_ACC) |=>
      mapAddr(pinOut, {13'h0000, memReq_q.addr[19:16]}) == pinOut)
    else $error("top address bits not on pins");

  a_cs_pin : assert property ( // R9
    (owned && memSt_q != M_ACC) |=> pinOut.priAddr[2])
    else $error("chip select active outside access");

  a_rd_oe : assert property ( // R4
    (memSt_q == M_ACC && !memReq_q.write && hostBusResetN) |=>
      !romOutputEnableNOut && romOutputEnableNOe && romWriteEnableNOut &&
      !pinOut.secDataOe[0])
    else $error("read strobe wrong");

  a_wr_we : assert property ( // R6
    (memSt_q == M_ACC && memReq_q.write && hostBusResetN) |=>
      !romWriteEnableNOut && pinOut.secDataOe[0] &&
      pinOut.secData[7:0] == memReq_q.wdata)
    else $error("write strobe or data wrong");

  a_rd_data : assert property ( // R10
    (memDone && !loadBusy_q) |=>
      rspValid && rspData == $past(secDataIn[7:0]))
    else $error("read data not returned");

  a_par_base : assert property ( // R15
    (memSt_q == M_LAT0 && loadBusy_q && loadCnt_q == '0) |->
      memReq_q.addr == PAR_LOAD_BASE)
    else $error("parallel load base wrong");

  a_ser_base : assert property ( // R15
    (i2cSt_q == I_BIT && i2cByte_q == 2'd1 && i2cBit_q == 4'd0) |->
      i2cSh_q == SER_LOAD_BASE)
    else $error("serial load base wrong");

  a_ide_pass : assert property ( // R16
    !owned |=> pinOut == $past(ideIn) && !idePinsOwned)
    else $error("ide pins not returned");

  a_scl_pin : assert property ( // R8
    (i2cSt_q != I_IDLE && hostBusResetN) |=>
      romOutputEnableNOe && romOutputEnableNOut == $past(sclHi))
    else $error("serial clock not on oe pin");

  a_rsp_time : assert property ( // R3
    userTake |-> ##[4:40] rspValid)
    else $error("memory access never answered");

  c_par_load : cover property ($fell(loadBusy) && loadSrc == SRC_PAR);
  c_ser_load : cover property ($fell(loadBusy) && loadSrc == SRC_SER);
  c_user_wr : cover property (userTake && req.write);
  c_user_rd : cover property (userTake && !req.write);

endmodule : rcl_loader

// *** verification/rcl_rom_model.sv ***
// rcl_rom_model: parallel rom behind two external address latches
// assumes the bench resolves the oe and we wires; md pins pull down;
// a two-wire rom answers on the same wires only while serOn is high
`timescale 1ns/10ps
module rcl_rom_model
  import rcl_pkg::*;
(
  input logic ref_clk,
  input rcl_pins_s pins,
  input logic [1:0] romAddrLatch,
  input logic oeN,
  input logic weN,
  input logic serOn,
  output logic sdaPull,
  output logic [15:0] secDataIn
);
  logic [7:0] mem [int];
  logic [7:0] loQ = 8'h00;
  logic [7:0] hiQ = 8'h00;
  logic weQ = 1'b1;
  logic csQ = 1'b1;
  logic [16:0] bus;
  logic [19:0] addr;
  assign bus = {pins.priCable, pins.secCable, pins.priAddr[1:0],
    pins.secSel, pins.secAddr, pins.secData[15:10], pins.priSel};
  // low byte latched first, top bits last
  assign addr = {bus[3:0], hiQ, loQ};
  always @(posedge ref_clk) begin
    if (romAddrLatch[0]) loQ <= bus[7:0];
    if (romAddrLatch[1]) hiQ <= bus[7:0];
    weQ <= weN;
    csQ <= pins.priAddr[2];
    // write lands as write enable and chip select rise together
    if (weN && !weQ && !csQ) mem[addr] = pins.secData[7:0];
  end
  // rom drives md only with cs and oe low
  always @* begin
    secDataIn[15:8] = ~pins.secData[15:8];
    secDataIn[7:0] = 8'h00;
    if (!pins.priAddr[2] && !oeN)
      secDataIn[7:0] = mem.exists(addr) ? mem[addr] :
        (addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]} ^ 8'h3C);
  end
  // two-wire rom: acks address and writes, reads from word address
  logic sclQ = 1'b1, sdaQ = 1'b1, addrByte = 1'b0, rdM = 1'b0;
  logic ackQ = 1'b0, rdQ = 1'b0;
  logic [3:0] cnt = 4'hF;
  logic [7:0] sh = 8'h00, out = 8'hFF, ptr = 8'h00;
  assign sdaPull = serOn && (ackQ || (rdQ && !out[7]));
  always @(posedge ref_clk) begin
    sclQ <= oeN;
    sdaQ <= weN;
    if (!serOn) begin
      cnt <= 4'hF;
      ackQ <= 1'b0;
      rdQ <= 1'b0;
    end else if (oeN && sclQ && sdaQ && !weN) begin
      // start or repeated start
      cnt <= 4'hF;
      addrByte <= 1'b1;
      rdM <= 1'b0;
      ackQ <= 1'b0;
      rdQ <= 1'b0;
    end else if (oeN && !sclQ && cnt < 4'h8) begin
      sh <= {sh[6:0], weN};
    end else if (!oeN && sclQ) begin
      cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
      if (cnt == 4'h7) begin
        rdQ <= 1'b0;
        ackQ <= addrByte ? sh[7:1] == SER_DEV_ADDR : !rdM;
        if (addrByte) rdM <= sh[0];
        if (!addrByte && !rdM) ptr <= sh;
      end else if (cnt == 4'h8) begin
        addrByte <= 1'b0;
        ackQ <= 1'b0;
        rdQ <= rdM;
        out <= ptr ^ 8'hC5;
        if (rdM) ptr <= ptr + 8'h01;
      end else begin
        out <= {out[6:0], 1'b1};
      end
    end
  end
endmodule : rcl_rom_model

// *** verification/test_rcl_loader.sv ***
// test_rcl_loader: straps, parallel and serial load, user accesses
// assumes pull-ups on oe and we pins; serial rom answers while serOn
`timescale 1ns/10ps
module test_rcl_loader
  import rcl_pkg::*;
;
  typedef struct {logic wr; logic [19:0] a; logic [7:0] d;} rcl_row_s;
  logic ref_clk, rstn, clkEn, hostBusResetN, ataFloatStrap;
  logic oeOut, oeOe, weOut, weOe, oeStrap, weStrap, oeWire, weWire;
  logic reqValid, reqReady, rspValid, cfgValid, loadBusy;
  logic allocEnable, idePinsOwned, serOn, sdaPull;
  logic [1:0] romAddrLatch;
  logic [15:0] secDataIn;
  logic [7:0] rspData, q;
  rcl_pins_s ideIn, pinOut;
  rcl_req_s req;
  rcl_cfg_s cfg;
  rcl_src_e loadSrc;
  rcl_cfg_s cfgQ [$];
  int miscompares = 0;
  int cmp_count = 0;
  int sclFalls = 0;
  int s0;
  rcl_row_s rows [6] = '{'{0, 20'hFFFFF, 8'h33}, '{1, 20'h12345, 8'hAA},
    '{0, 20'h12345, 8'hAA}, '{0, 20'h00000, 8'h3C},
    '{1, 20'h80001, 8'h55}, '{0, 20'h80001, 8'h55}};
  // open drain sda, push-pull scl, pull-ups otherwise
  assign oeWire = oeOe ? oeOut : oeStrap;
  assign weWire = ((weOe && !weOut) || sdaPull) ? 1'b0 : weStrap;
  rcl_loader #(.LOAD_BYTES(3)) i_rcl_loader (.ref_clk(ref_clk),
    .rstn(rstn), .clkEn(clkEn), .hostBusResetN(hostBusResetN),
    .ataFloatStrap(ataFloatStrap), .ideIn(ideIn), .secDataIn(secDataIn),
    .pinOut(pinOut), .romOutputEnableNIn(oeWire),
    .romOutputEnableNOut(oeOut), .romOutputEnableNOe(oeOe),
    .romWriteEnableNIn(weWire), .romWriteEnableNOut(weOut),
    .romWriteEnableNOe(weOe), .romAddrLatch(romAddrLatch),
    .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .cfgValid(cfgValid),
    .cfg(cfg), .loadBusy(loadBusy), .allocEnable(allocEnable),
    .loadSrc(loadSrc), .idePinsOwned(idePinsOwned));
  rcl_rom_model i_rcl_rom_model (.ref_clk(ref_clk), .pins(pinOut),
    .romAddrLatch(romAddrLatch), .oeN(oeWire), .weN(weWire),
    .serOn(serOn), .sdaPull(sdaPull), .secDataIn(secDataIn));
  // ------------------------------------------------------------
  // monitors and helpers
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (cfgValid === 1'b1) cfgQ.push_back(cfg);
  end
  always @(negedge oeWire) sclFalls++;
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chkBit(string n, logic e, logic g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s exp %b got %b", n, e, g);
      miscompares++;
    end
  endtask : chkBit
  task automatic chkVal(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("mismatch %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask : chkVal
  task automatic guard(int n, int lim);
    if (n >= lim) begin
      miscompares++;
      finish_test();
    end
  endtask : guard
  task automatic busReset(logic oe, logic we, logic fl);
    @(negedge ref_clk);
    hostBusResetN = 1'b0;
    oeStrap = oe;
    weStrap = we;
    ataFloatStrap = fl;
    repeat (4) @(negedge ref_clk);
    hostBusResetN = 1'b1;
    repeat (3) @(negedge ref_clk);
    oeStrap = 1'b1;
    weStrap = 1'b1;
  endtask : busReset
  task automatic waitIdle();
    int n;
    n = 0;
    while (loadBusy !== 1'b0 && n < 40000) begin
      @(negedge ref_clk);
      n++;
    end
    guard(n, 40000);
    // last byte reaches the queue one edge after busy falls
    @(negedge ref_clk);
  endtask : waitIdle
  task automatic access(logic wr, logic [19:0] a, logic [7:0] d,
      output logic [7:0] qo);
    int n;
    int lat;
    @(negedge ref_clk);
    req = '{write: wr, addr: a, wdata: d};
    reqValid = 1'b1;
    n = 0;
    while (reqReady !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    guard(n, 500);
    @(negedge ref_clk);
    reqValid = 1'b0;
    lat = 0;
    while (rspValid !== 1'b1 && lat < 100) begin
      @(posedge ref_clk);
      #1;
      lat++;
      if (lat == 5) chkBit("owned", 1'b1, idePinsOwned);
      if (lat == 10) chkBit("cs", 1'b0, pinOut.priAddr[2]);
    end
    guard(lat, 100);
    chkVal("latency", 15, lat);
    qo = rspData;
  endtask : access
  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    rstn = 1'b0;
    clkEn = 1'b1;
    hostBusResetN = 1'b0;
    ataFloatStrap = 1'b1;
    oeStrap = 1'b1;
    weStrap = 1'b1;
    reqValid = 1'b0;
    serOn = 1'b0;
    req = '0;
    ideIn = '{3'h5, 3'h2, 2'h1, 2'h2, 1'b1, 1'b0, 16'hA55A, 2'h3};
    repeat (12) @(negedge ref_clk);
    chkVal("rstPins", 32'(PINS_RST), 32'(pinOut));
    chkBit("rstOeDrive", 1'b0, oeOe);
    chkBit("rstReady", 1'b0, reqReady);
    rstn = 1'b1;
    // parallel load: oe high, we high, float high
    busReset(1'b1, 1'b1, 1'b1);
    chkBit("alloc", 1'b0, allocEnable);
    chkVal("src", 32'(SRC_PAR), 32'(loadSrc));
    waitIdle();
    chkVal("cfgCount", 3, cfgQ.size());
    foreach (cfgQ[i]) begin
      q = 8'(20'h01000 + i) ^ 8'h10 ^ 8'h3C;
      chkVal("cfgIdx", i, 32'(cfgQ[i].idx));
      chkVal("cfgData", 32'(q), 32'(cfgQ[i].data));
    end
    repeat (3) @(negedge ref_clk);
    chkVal("idePins", 32'(ideIn), 32'(pinOut));
    chkBit("ownedIdle", 1'b0, idePinsOwned);
    foreach (rows[i]) begin
      access(rows[i].wr, rows[i].a, rows[i].d, q);
      if (!rows[i].wr) chkVal("rdData", 32'(rows[i].d), 32'(q));
    end
    // serial load from the two-wire rom: oe strap low, float low
    cfgQ.delete();
    busReset(1'b0, 1'b1, 1'b0);
    serOn = 1'b1;
    chkBit("allocEn", 1'b1, allocEnable);
    chkVal("srcSer", 32'(SRC_SER), 32'(loadSrc));
    chkBit("serBusy", 1'b1, loadBusy);
    waitIdle();
    serOn = 1'b0;
    chkVal("serCount", 3, cfgQ.size());
    foreach (cfgQ[i]) begin
      chkVal("serData", 32'(8'(i) ^ 8'hC5), 32'(cfgQ[i].data));
    end
    // no serial rom answers: load aborts after the address byte
    s0 = sclFalls;
    busReset(1'b1, 1'b1, 1'b0);
    waitIdle();
    chkBit("sclPulses", 1'b1, (sclFalls - s0) >= 9);
    // no load: we strap low, float high
    busReset(1'b1, 1'b0, 1'b1);
    chkVal("srcNone", 32'(SRC_NONE), 32'(loadSrc));
    chkBit("noBusy", 1'b0, loadBusy);
    access(1'b0, 20'h12345, 8'h00, q);
    chkVal("reread", 32'(8'hAA), 32'(q));
    // clock enable low freezes the pins
    repeat (3) @(negedge ref_clk);
    clkEn = 1'b0;
    ideIn.secData = 16'h5AA5;
    repeat (3) @(negedge ref_clk);
    chkVal("frozen", 32'h0000A55A, 32'(pinOut.secData));
    clkEn = 1'b1;
    repeat (2) @(negedge ref_clk);
    chkVal("thawed", 32'h00005AA5, 32'(pinOut.secData));
    finish_test();
  end
endmodule : test_rcl_loader
